// ---- dv/acm_macro_model.sv ----
// Purpose: far-side source of the digitised input word
// Assumes: one fixed word per channel code
// Notes:   word is undefined while disabled, so it is shown inverted
`timescale 1ns/1ps
`default_nettype none
module acm_macro_model
(
   input  wire logic [4:0]  chan_i,   // channel select
   input  wire logic        enb_n_i,  // enable, active low
   output logic      [11:0] sample_o  // word of selected input
);
   logic [11:0] word;
   assign word = {chan_i, ~chan_i, chan_i[1:0]};
   assign sample_o = enb_n_i ? ~word : word;
endmodule : acm_macro_model
`default_nettype wire

// ---- dv/acm_top_tb_top.sv ----
// Purpose: self-checking bench of the converter control block
// Assumes: CE_I high but for one freeze, full strobes but for one write
// Notes:   bus master per AXI4-Lite, queue exq holds expected results
`timescale 1ns/1ps
`default_nettype none
`include "acm_defs.svh"
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin fails++; $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module acm_top_tb_top;
   localparam int T = `ACM_CONV_CYCLES * `ACM_CLK_DIV;
   localparam int SETTLE = 400; // 10 us of 25 ns cycles
   logic        clk, rst, awv, wv, bry, arv, rry, lo, ce;
   logic [3:0]  ws;
   logic        awr, wr, bv, arr, rv, enbn, stp, eoc;
   logic [11:0] awa, ara, samp, res;
   logic [31:0] wd, rd, rdat, lf;
   logic [1:0]  bresp, rresp, rsp;
   logic [4:0]  sel;
   int          fails, n_tests, cnt, n, sel_m;
   logic [11:0] exq[$];

   acm_top DUT (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .SAMPLE_I(samp),
      .S_AWADDR_I(awa), .S_AWVALID_I(awv), .S_AWREADY_O(awr), .S_WDATA_I(wd),
      .S_WSTRB_I(ws), .S_WVALID_I(wv), .S_WREADY_O(wr), .S_BRESP_O(bresp),
      .S_BVALID_O(bv), .S_BREADY_I(bry), .S_ARADDR_I(ara), .S_ARVALID_I(arv),
      .S_ARREADY_O(arr), .S_RDATA_O(rdat), .S_RRESP_O(rresp), .S_RVALID_O(rv),
      .S_RREADY_I(rry), .CHANNEL_SELECT_O(sel), .ENB_N_O(enbn), .STOP_O(stp),
      .CONVERSION_RESULT_O(res), .EOC_O(eoc));
   acm_macro_model far (.chan_i(sel), .enb_n_i(enbn), .sample_o(samp));

   // conversion clock is derived inside from this one clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic wr32(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wd  <= d;
      awv <= 1'b1;
      wv  <= 1'b1;
      bry <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr) wv <= 1'b0;
      end
      while (!(bry && bv));
      rsp = bresp;
      bry <= 1'b0;
   endtask : wr32

   task automatic rd32(input logic [11:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end
      while (!(rry && rv));
      rd = rdat;
      rsp = rresp;
      rry <= 1'b0;
   endtask : rd32

   task automatic count_is;
      rd32(`ACM_OFS_COUNT);
      `CHK("count", 32'(cnt), rd)
   endtask : count_is

   task automatic conv(input logic [4:0] c);
      wr32(`ACM_OFS_CTRL, {19'h0, c, 8'h01});
      n = 0;
      lo = 1'b0;
      while (!(lo && eoc === 1'b1) && n < 200)
      begin
         @(posedge clk);
         n++;
         if (eoc === 1'b0) lo = 1'b1;
      end
      exq.push_back({c, ~c, c[1:0]});
      cnt++;
      `CHK("eoc_low", 1'b1, lo)
      `CHK("eoc_time", 1'b1, n >= T - 2 && n <= T + 8)
      `CHK("result", exq[$], res)
      rd32(`ACM_OFS_RESULT);
      `CHK("result_reg", {20'h0, exq[$]}, rd)
      rd32(`ACM_OFS_STATUS);
      `CHK("status", 32'h1, rd)
      count_is;
   endtask : conv

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up

   initial
   begin
      {rst, awv, wv, bry, arv, rry, awa, ara, wd} = {1'b1, 5'h0, 12'h0, 12'h0, 32'h0};
      ce = 1'b1;
      ws = 4'hf;
      fails = 0;
      n_tests = 0;
      cnt = 0;
      lf = 32'hdd28;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      `CHK("sel_rst", 5'h01, sel)
      `CHK("enb_rst", 1'b1, enbn)
      `CHK("stop_rst", 1'b0, stp)
      rd32(`ACM_OFS_CTRL);
      `CHK("ctrl_rst", 32'h102, rd)
      rd32(12'h010);
      `CHK("bad_rd", {`ACM_RESP_SLVERR, 32'h0}, {rsp, rd})
      wr32(12'h014, 32'h0);
      `CHK("bad_wr", `ACM_RESP_SLVERR, rsp)
      sel_m = 1;
      for (int c = 0; c < 19; c++)
      begin
         wr32(`ACM_OFS_CTRL, {19'h0, 5'(c), 8'h02});
         if (c >= 1 && c <= 17) sel_m = c;
         @(posedge clk);
         `CHK("sel", 5'(sel_m), sel)
      end
      // byte 1 only: channel moves, start, enable and stop bits are ignored
      ws <= 4'h2;
      wr32(`ACM_OFS_CTRL, 32'h0000_0505);
      ws <= 4'hf;
      @(posedge clk);
      `CHK("strb_sel", 5'h05, sel)
      `CHK("strb_enb", 1'b1, enbn)
      `CHK("strb_stop", 1'b0, stp)
      wr32(`ACM_OFS_CTRL, 32'h1100);
      @(posedge clk);
      `CHK("enb_on", 1'b0, enbn)
      repeat (SETTLE) @(posedge clk);
      conv(5'h11);
      for (int i = 0; i < 4; i++)
      begin
         lf = lfsr(lf);
         conv(5'(1 + lf % 17));
      end
      // abort in mid-conversion by disabling
      wr32(`ACM_OFS_CTRL, 32'h301);
      // frozen long enough for a free-running conversion to finish
      ce <= 1'b0;
      repeat (2 * T) @(posedge clk);
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      rd32(`ACM_OFS_STATUS);
      `CHK("ce_hold", 1'b1, rd[1])
      repeat (12) @(posedge clk);
      wr32(`ACM_OFS_CTRL, 32'h302);
      repeat (T + 20) @(posedge clk);
      `CHK("eoc_abort", 1'b0, eoc)
      count_is;
      wr32(`ACM_OFS_CTRL, 32'h104);
      @(posedge clk);
      `CHK("stop_on", 1'b1, stp)
      wr32(`ACM_OFS_CTRL, 32'h105);
      repeat (T + 20) @(posedge clk);
      count_is;
      wr32(`ACM_OFS_CTRL, 32'h100);
      repeat (8) @(posedge clk);
      conv(5'h10);
      wrap_up;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      wrap_up;
   end
endmodule : acm_top_tb_top
`default_nettype wire

// ---- hdl/acm_conv_if.sv ----
// Purpose: bundle between register slave and conversion core
// Assumes: one clock
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface acm_conv_if;
   logic        start;
   logic        enb_n;
   logic        stop;
   logic [4:0]  channel_select;
   logic [11:0] conversion_result;
   logic        eoc;
   logic        busy;
   logic [15:0] done_count;
   modport ctrl (output start, enb_n, stop, channel_select,
                 input conversion_result, eoc, busy, done_count);
   modport core (input start, enb_n, stop, channel_select,
                 output conversion_result, eoc, busy, done_count);
endinterface : acm_conv_if
`default_nettype wire

// ---- hdl/acm_core.sv ----
// Purpose: successive conversion sequencer with end-of-conversion flag
// Assumes: analog sample arrives as a 12-bit word on sample_i
// Notes:   conversion clock is the system clock divided by CLK_DIV
`timescale 1ns/1ps
`default_nettype none
`include "acm_defs.svh"
module acm_core
   import acm_pkg::*;
#(
   parameter int CLK_DIV = `ACM_CLK_DIV
)
(
   input  wire logic        clk_i,   // system clock
   input  wire logic        rst_i,   // sync reset
   input  wire logic        ce_i,    // clock enable
   input  wire logic [11:0] sample_i,// analog input model word
   acm_conv_if.core         cv       // control bundle
);
   localparam int CONV = `ACM_CONV_CYCLES;
   localparam int ACQ  = `ACM_ACQ_CYCLES;
   if (CLK_DIV < 1 || CLK_DIV > 255)
   begin : g_div_range
      $error("CLK_DIV out of range");
   end

   acm_state_type state;
   logic [7:0]    div_cnt;
   logic          tick;
   logic [3:0]    cyc;
   logic [11:0]   hold;
   logic          pend;

   assign tick = (div_cnt == 8'(CLK_DIV - 1));

   always_ff @(posedge clk_i)
      if (rst_i) div_cnt <= 8'h00;
      else if (ce_i) div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;

   // start requests wait for the next conversion-clock edge
   always_ff @(posedge clk_i)
      if (rst_i) pend <= 1'b0;
      else if (ce_i)
      begin
         if (cv.start) pend <= 1'b1;
         else if (tick) pend <= 1'b0;
      end

   always_ff @(posedge clk_i)
      if (rst_i)
      begin
         state <= ST_OFF;
         cyc   <= 4'h0;
         hold  <= 12'h000;
         cv.eoc <= 1'b0;
         cv.conversion_result <= 12'h000;
         cv.done_count <= 16'h0000;
      end
      else if (ce_i)
      begin
         if (cv.stop || cv.enb_n)
         begin
            state <= ST_OFF;
            cyc   <= 4'h0;
         end
         else if (tick)
         begin
            case (state)
               ST_OFF: state <= ST_IDLE;
               ST_IDLE:
                  if (pend || cv.start)
                  begin
                     state  <= ST_ACQ;
                     cyc    <= 4'h1;
                     cv.eoc <= 1'b0;
                  end
               ST_ACQ:
               begin
                  hold  <= sample_i;
                  cyc   <= cyc + 4'h1;
                  if (cyc == 4'(ACQ)) state <= ST_RESOLVE;
               end
               ST_RESOLVE:
                  if (cyc == 4'(CONV))
                  begin
                     cv.conversion_result <= hold;
                     cv.eoc   <= 1'b1;
                     cv.done_count <= cv.done_count + 16'h0001;
                     state    <= ST_IDLE;
                  end
                  else cyc <= cyc + 4'h1;
               default: state <= ST_OFF;
            endcase
         end
      end

   assign cv.busy = (state == ST_ACQ) || (state == ST_RESOLVE);

   // conversion-clock counter for checking the 13-cycle latency
   logic [7:0] tick_cnt;
   always_ff @(posedge clk_i)
      if (rst_i) tick_cnt <= 8'h00;
      else if (ce_i && tick) tick_cnt <= (state == ST_IDLE) ? 8'h00 : tick_cnt + 8'h01;

   AST_EOC_AFTER_13: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(cv.eoc) |-> $past(tick_cnt) == 8'(CONV - 1))
      else $error("end of conversion not after 13 cycles");
   AST_STOP_IDLES: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && cv.stop) |=> !cv.busy)
      else $error("stop did not power down");
   AST_ENB_IDLES: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && cv.enb_n) |=> !cv.busy)
      else $error("disable did not halt");
   AST_EOC_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(cv.busy) |-> !cv.eoc)
      else $error("flag still high at new conversion");
   AST_RESULT_STABLE: assert property (@(posedge clk_i) disable iff (rst_i)
      (cv.eoc && $past(cv.eoc)) |-> $stable(cv.conversion_result))
      else $error("result moved while flag high");
   AST_ACQ_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ST_ACQ && tick && ce_i && !cv.stop && !cv.enb_n) |=> state == ST_RESOLVE)
      else $error("acquisition longer than one cycle");
endmodule : acm_core
`default_nettype wire

// ---- hdl/acm_defs.svh ----
// Purpose: constants of the converter control and result block
// Assumes: 32-bit register words on the control bus
// Notes:   offsets are byte addresses
`ifndef ACM_DEFS_SVH
`define ACM_DEFS_SVH
`define ACM_OFS_CTRL        12'h000
`define ACM_OFS_STATUS      12'h004
`define ACM_OFS_RESULT      12'h008
`define ACM_OFS_COUNT       12'h00c
`define ACM_CTRL_START_BIT  0
`define ACM_CTRL_ENB_BIT    1
`define ACM_CTRL_STOP_BIT   2
`define ACM_CTRL_SEL_LSB    8
`define ACM_SEL_RESET       5'h01
`define ACM_SEL_FIRST       5'h01
`define ACM_SEL_LAST        5'h11
`define ACM_ENB_RESET       1'h1
`define ACM_STOP_RESET      1'h0
`define ACM_CONV_CYCLES     13
`define ACM_ACQ_CYCLES      1
`define ACM_CLK_DIV         4
`define ACM_RESP_OKAY       2'h0
`define ACM_RESP_SLVERR     2'h2
`endif

// ---- hdl/acm_pkg.sv ----
// Purpose: types shared by the converter control block
// Assumes: nothing
// Notes:   constants live in acm_defs.svh
package acm_pkg;
   typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_ACQ, ST_RESOLVE} acm_state_type;
endpackage : acm_pkg

// ---- hdl/acm_top.sv ----
// Purpose: AXI4-Lite control of the 12-bit converter macro
// Assumes: sample word of the selected channel given on SAMPLE_I
// Notes:   single-beat slave, one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
`include "acm_defs.svh"
module acm_top
   import acm_pkg::*;
(
   input  wire logic        CLK_SYS_I,     // 40 MHz system clock
   input  wire logic        RST_I,         // sync reset, active high
   input  wire logic        CE_I,          // clock enable
   input  wire logic [11:0] SAMPLE_I,      // digitised input of selected channel
   input  wire logic [11:0] S_AWADDR_I,    // write address
   input  wire logic        S_AWVALID_I,   // write address valid
   output logic             S_AWREADY_O,   // write address ready
   input  wire logic [31:0] S_WDATA_I,     // write data
   input  wire logic [3:0]  S_WSTRB_I,     // write strobes
   input  wire logic        S_WVALID_I,    // write data valid
   output logic             S_WREADY_O,    // write data ready
   output logic [1:0]       S_BRESP_O,     // write response
   output logic             S_BVALID_O,    // write response valid
   input  wire logic        S_BREADY_I,    // write response ready
   input  wire logic [11:0] S_ARADDR_I,    // read address
   input  wire logic        S_ARVALID_I,   // read address valid
   output logic             S_ARREADY_O,   // read address ready
   output logic [31:0]      S_RDATA_O,     // read data
   output logic [1:0]       S_RRESP_O,     // read response
   output logic             S_RVALID_O,    // read data valid
   input  wire logic        S_RREADY_I,    // read data ready
   output logic [4:0]       CHANNEL_SELECT_O, // channel select to macro
   output logic             ENB_N_O,       // converter enable, active low
   output logic             STOP_O,        // power-down
   output logic [11:0]      CONVERSION_RESULT_O, // last result
   output logic             EOC_O          // end of conversion flag
);
   acm_conv_if cv ();

   acm_core #(.CLK_DIV(`ACM_CLK_DIV)) u_core (
      .clk_i    (CLK_SYS_I),
      .rst_i    (RST_I),
      .ce_i     (CE_I),
      .sample_i (SAMPLE_I),
      .cv       (cv)
   );

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == `ACM_OFS_CTRL) || (a == `ACM_OFS_STATUS) ||
               (a == `ACM_OFS_RESULT) || (a == `ACM_OFS_COUNT);
   endfunction : mapped

   function automatic logic legal_code(input logic [4:0] c);
      legal_code = (c >= `ACM_SEL_FIRST) && (c <= `ACM_SEL_LAST);
   endfunction : legal_code

   logic        aw_got;
   logic        w_got;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic [4:0]  sel;
   logic        enb_n;
   logic        stop;
   logic        start;
   logic        wr_fire;
   logic [4:0]  next_sel;

   assign wr_fire = aw_got && w_got && !S_BVALID_O;

   // write address and data accepted in either order
   always_ff @(posedge CLK_SYS_I)
      if (RST_I)
      begin
         aw_got <= 1'b0;
         w_got  <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         S_AWREADY_O <= 1'b0;
         S_WREADY_O  <= 1'b0;
      end
      else if (CE_I)
      begin
         S_AWREADY_O <= !aw_got && !S_AWREADY_O && !S_BVALID_O;
         S_WREADY_O  <= !w_got && !S_WREADY_O && !S_BVALID_O;
         if (S_AWVALID_I && S_AWREADY_O)
         begin
            aw_got  <= 1'b1;
            aw_addr <= S_AWADDR_I;
            S_AWREADY_O <= 1'b0;
         end
         if (S_WVALID_I && S_WREADY_O)
         begin
            w_got  <= 1'b1;
            w_data <= S_WDATA_I;
            w_strb <= S_WSTRB_I;
            S_WREADY_O <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
         end
      end

   // only legal channel codes are kept
   always_comb
   begin
      next_sel = w_data[`ACM_CTRL_SEL_LSB +: 5];
      if (!legal_code(next_sel))
         next_sel = sel;
   end

   always_ff @(posedge CLK_SYS_I)
      if (RST_I)
      begin
         sel   <= `ACM_SEL_RESET;
         enb_n <= `ACM_ENB_RESET;
         stop  <= `ACM_STOP_RESET;
         start <= 1'b0;
         S_BVALID_O <= 1'b0;
         S_BRESP_O  <= `ACM_RESP_OKAY;
      end
      else if (CE_I)
      begin
         start <= 1'b0;
         if (S_BVALID_O && S_BREADY_I) S_BVALID_O <= 1'b0;
         if (wr_fire)
         begin
            S_BVALID_O <= 1'b1;
            S_BRESP_O  <= mapped(aw_addr) ? `ACM_RESP_OKAY : `ACM_RESP_SLVERR;
            if (aw_addr == `ACM_OFS_CTRL)
            begin
               if (w_strb[0])
               begin
                  start <= w_data[`ACM_CTRL_START_BIT];
                  enb_n <= w_data[`ACM_CTRL_ENB_BIT];
                  stop  <= w_data[`ACM_CTRL_STOP_BIT];
               end
               if (w_strb[1]) sel <= next_sel;
            end
         end
      end

   assign cv.start = start;
   assign cv.enb_n = enb_n;
   assign cv.stop  = stop;
   assign cv.channel_select = sel;

   always_ff @(posedge CLK_SYS_I)
      if (RST_I)
      begin
         S_ARREADY_O <= 1'b0;
         S_RVALID_O  <= 1'b0;
         S_RDATA_O   <= 32'h0000_0000;
         S_RRESP_O   <= `ACM_RESP_OKAY;
      end
      else if (CE_I)
      begin
         S_ARREADY_O <= !S_ARREADY_O && !S_RVALID_O;
         if (S_RVALID_O && S_RREADY_I) S_RVALID_O <= 1'b0;
         if (S_ARVALID_I && S_ARREADY_O)
         begin
            S_ARREADY_O <= 1'b0;
            S_RVALID_O  <= 1'b1;
            S_RRESP_O   <= mapped(S_ARADDR_I) ? `ACM_RESP_OKAY : `ACM_RESP_SLVERR;
            case (S_ARADDR_I)
               `ACM_OFS_CTRL:   S_RDATA_O <= {19'h0, sel, 5'h0, stop, enb_n, 1'b0};
               `ACM_OFS_STATUS: S_RDATA_O <= {30'h0, cv.busy, cv.eoc};
               `ACM_OFS_RESULT: S_RDATA_O <= {20'h0, cv.conversion_result};
               `ACM_OFS_COUNT:  S_RDATA_O <= {16'h0, cv.done_count};
               default:         S_RDATA_O <= 32'h0000_0000;
            endcase
         end
      end

   // pin outputs registered
   always_ff @(posedge CLK_SYS_I)
      if (RST_I)
      begin
         CHANNEL_SELECT_O <= `ACM_SEL_RESET;
         ENB_N_O <= `ACM_ENB_RESET;
         STOP_O  <= `ACM_STOP_RESET;
         CONVERSION_RESULT_O <= 12'h000;
         EOC_O   <= 1'b0;
      end
      else if (CE_I)
      begin
         CHANNEL_SELECT_O <= sel;
         ENB_N_O <= enb_n;
         STOP_O  <= stop;
         CONVERSION_RESULT_O <= cv.conversion_result;
         EOC_O   <= cv.eoc;
      end

   // enabled cycles spent busy, held against the conversion span
   localparam int SPAN = `ACM_CONV_CYCLES * `ACM_CLK_DIV;
   logic [11:0] busy_len;

   if (SPAN > 4095)
   begin : g_span_range
      $error("conversion span too long for its counter");
   end

   always_ff @(posedge CLK_SYS_I)
      if (RST_I) busy_len <= 12'h000;
      else if (CE_I) busy_len <= cv.busy ? busy_len + 12'h001 : 12'h000;

   // bus steps
   sequence s_wr_taken;
      CE_I && wr_fire;
   endsequence

   sequence s_wr_answered;
      S_BVALID_O && !S_AWREADY_O && !S_WREADY_O;
   endsequence

   sequence s_rd_taken;
      CE_I && S_ARVALID_I && S_ARREADY_O;
   endsequence

   sequence s_rd_answered;
      S_RVALID_O && !S_ARREADY_O;
   endsequence

   property p_b_holds;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (S_BVALID_O && !S_BREADY_I) |=> (S_BVALID_O && $stable(S_BRESP_O));
   endproperty

   property p_r_holds;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (S_RVALID_O && !S_RREADY_I) |=>
         (S_RVALID_O && $stable(S_RDATA_O) && $stable(S_RRESP_O));
   endproperty

   property p_sel_keep;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (CE_I && wr_fire && aw_addr == `ACM_OFS_CTRL && w_strb[1] &&
       !legal_code(w_data[`ACM_CTRL_SEL_LSB +: 5])) |=> sel == $past(sel);
   endproperty

   property p_pins_follow;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      CE_I |=> (CHANNEL_SELECT_O == $past(sel)) && (ENB_N_O == $past(enb_n)) &&
               (STOP_O == $past(stop));
   endproperty

   AST_WR_ANSWER: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      s_wr_taken |=> s_wr_answered)
      else $error("write response not raised after both halves taken");

   AST_RD_ANSWER: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      s_rd_taken |=> s_rd_answered)
      else $error("read data not raised after address taken");

   AST_B_HOLDS: assert property (p_b_holds)
      else $error("write response dropped before ready");

   AST_R_HOLDS: assert property (p_r_holds)
      else $error("read data dropped before ready");

   AST_W_PENDING: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      S_BVALID_O |-> (!S_AWREADY_O && !S_WREADY_O))
      else $error("write channel ready while response pending");

   AST_AR_PENDING: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      S_RVALID_O |-> !S_ARREADY_O)
      else $error("read address ready while data pending");

   AST_START_PULSE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      (CE_I && start) |=> !start)
      else $error("start request longer than one cycle");

   AST_SEL_KEEP: assert property (p_sel_keep)
      else $error("illegal channel code changed the select");

   AST_PINS_FOLLOW: assert property (p_pins_follow)
      else $error("control pins do not follow their registers");

   AST_BUSY_SPAN: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      ($fell(cv.busy) && cv.eoc) |-> busy_len == 12'(SPAN))
      else $error("conversion span differs from thirteen conversion cycles");

   AST_EOC_FALL: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      $fell(EOC_O) |-> $past(cv.busy))
      else $error("flag fell without a new conversion");

   AST_FREEZE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      !CE_I |=> $stable(EOC_O) && $stable(CONVERSION_RESULT_O) &&
                $stable(S_BVALID_O) && $stable(S_RVALID_O))
      else $error("outputs moved while clock enable low");

   AST_SEL_LEGAL: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      legal_code(CHANNEL_SELECT_O))
      else $error("illegal channel code");
   AST_EOC_PIN: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      $rose(EOC_O) |-> CONVERSION_RESULT_O == $past(cv.conversion_result))
      else $error("result not valid with flag");
endmodule : acm_top
`default_nettype wire
